// [bwm_pkg.sv]
/*
 * Constants shared by the debug event block: register offsets, field
 * positions, reset values and instruction encodings.
 * Assumes a 32-bit AHB-Lite register bus and one core clock.
 */
package bwm_pkg;
    localparam logic [7:0]  BWM_OFF_BP_VALUE   = 8'h00;
    localparam logic [7:0]  BWM_OFF_BP_CONTROL = 8'h04;
    localparam logic [7:0]  BWM_OFF_WP_VALUE   = 8'h08;
    localparam logic [7:0]  BWM_OFF_WP_CONTROL = 8'h0c;
    localparam logic [7:0]  BWM_OFF_CATCH_CTRL = 8'h10;
    localparam logic [7:0]  BWM_OFF_HYP_CONFIG = 8'h14;
    localparam logic [7:0]  BWM_OFF_STATUS     = 8'h18;
    localparam logic [7:0]  BWM_OFF_EFF_COUNT  = 8'h1c;
    // Control fields: enable bit 0, byte select from bit 5, link from 16
    localparam int          BWM_CTL_EN_BIT     = 0;
    localparam int          BWM_CTL_CTX_BIT    = 1;
    localparam int          BWM_CTL_LINKED_BIT = 2;
    localparam int          BWM_CTL_BAS_LSB    = 5;
    localparam int          BWM_CTL_LBN_LSB    = 16;
    localparam int          BWM_CTL_MASK_LSB   = 24;
    localparam logic [3:0]  BWM_BAS_HI_HALF    = 4'hc;
    localparam logic [3:0]  BWM_BAS_ALL        = 4'hf;
    localparam logic [3:0]  BWM_BAS_NONE       = 4'h0;
    localparam logic [7:0]  BWM_WBAS_ALL       = 8'hff;
    localparam logic [4:0]  BWM_MASK_NONE      = 5'h00;
    localparam logic [3:0]  BWM_COND_ALWAYS    = 4'he;
    localparam logic [31:0] BWM_RST_WORD       = 32'h00000000;
    localparam logic [4:0]  BWM_RST_HYP_COUNTER_PARTITION       = 5'h1f;
    localparam logic [3:0]  BWM_EL_NONE        = 4'h0;
    localparam int          BWM_LBN_W          = 4;
    localparam int          BWM_HYP_COUNTER_PARTITION_W         = 5;
    // Unknown value shown in link field when link target is bad
    localparam logic [3:0]  BWM_LBN_UNKNOWN    = 4'hf;
    typedef enum logic [1:0] {
        BWM_INSTR_OTHER,
        BWM_INSTR_SOFT_BP,
        BWM_INSTR_HALT
    } bwm_instr_t;
endpackage

// [bwm_addr_match.sv]
/*
 * Breakpoint address match for one fetched instruction.
 * Assumes the core presents a halfword-aligned fetch address each cycle.
 */
module bwm_addr_match
    import bwm_pkg::*;
(
    input  wire logic [31:0] bp_value,
    input  wire logic [3:0]  bp_bas,
    input  wire logic        bp_en,
    input  wire logic [31:0] pc,
    input  wire logic        compact,
    input  wire logic        length_flag,
    output logic             hit
);
    logic        word_same;
    logic        lo_half;
    logic        hi_half;
    always_comb begin
        word_same = (pc[31:2] == bp_value[31:2]);
        lo_half   = word_same && !pc[1] && (bp_bas[1:0] != 2'b00);
        hi_half   = word_same && pc[1] && (bp_bas[3:2] != 2'b00);
        hit       = 1'b0;
        // Zero byte select never matches
        if (bp_en && (bp_bas != BWM_BAS_NONE)) begin
            if (compact) begin
                // Instruction at value plus two with full select
                hit = hi_half || lo_half;
            end else if (bp_bas == BWM_BAS_HI_HALF) begin
                // Fixed-width, upper lanes only
                hit = word_same && !length_flag;
            end else if (lo_half) begin
                hit = 1'b1;
            end else begin
                // Second halfword only
                hit = word_same && (bp_bas[3:2] != 2'b00) && !length_flag;
            end
        end
    end
endmodule

// [bwm_debug_events.sv]
/*
 * Debug event logic: breakpoint and watchpoint matching,
 * unconditional soft breakpoint and halt, exception catch, counter partition field.
 * Assumes a single AHB-Lite master and a core that reports one
 * instruction and one data access per cycle.
 */
// The register offsets and the AHB-Lite register port are this design's own decisions.
module bwm_debug_events
    import bwm_pkg::*;
#(
    parameter int NUM_BP      = 4,
    parameter int NUM_COUNTER = 6
) (
    input  wire logic        REF_CLK,
    input  wire logic        NRST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        INSTR_VALID,
    input  wire logic [31:0] INSTR_PC,
    input  wire logic        INSTR_COMPACT,
    input  wire logic        INSTR_LENGTH_FLAG,
    input  wire bwm_pkg::bwm_instr_t INSTR_KIND,
    input  wire logic [3:0]  INSTR_COND,
    input  wire logic        INSTR_COND_PASS,
    input  wire logic        INSTR_CTX_SYNC,
    input  wire logic        INSTR_IS_BARRIER,
    input  wire logic [1:0]  CUR_EL,
    input  wire logic        NONSECURE,
    input  wire logic        HALT_ALLOWED,
    input  wire logic        DATA_VALID,
    input  wire logic [31:0] DATA_ADDR,
    input  wire logic [7:0]  DATA_LANES,
    output logic             BP_EVENT,
    output logic             WP_EVENT,
    output logic [7:0]       WP_BYTE,
    output logic             SOFT_BP_TAKEN,
    output logic             HALT_TAKEN,
    output logic             CATCH_HALT,
    output logic [4:0]       EFF_COUNTERS
);
    import bwm_pkg::*;
    default clocking bwm_cb @(posedge REF_CLK);
    endclocking
    default disable iff (!NRST);

    typedef enum logic [1:0] {
        BWM_WP_IDLE,
        BWM_WP_SPLIT
    } bwm_wp_state_t;

    function automatic logic [7:0] bwm_low_bit(input logic [7:0] v);
        bwm_low_bit = v & (~v + 8'h01);
    endfunction

    function automatic logic link_ok(input logic [3:0] n,
                                     input logic [31:0] ctl_of_bp0,
                                     input int nbp);
        link_ok = (32'(n) < 32'(nbp)) && (n == 4'h0)
                  && ctl_of_bp0[BWM_CTL_CTX_BIT];
    endfunction

    // Register file
    logic [31:0]   bp_value_reg, bp_value_next;
    logic [31:0]   bp_ctl_reg, bp_ctl_next;
    logic [31:0]   wp_value_reg, wp_value_next;
    logic [31:0]   wp_ctl_reg, wp_ctl_next;
    logic [3:0]    catch_reg, catch_next;
    logic [4:0]    hyp_counter_partition_reg, hyp_counter_partition_next;
    logic [7:0]    wr_addr_reg, wr_addr_next;
    logic          wr_pend_reg, wr_pend_next;
    logic [31:0]   rdata_reg, rdata_next;
    // Event state
    logic          bp_ev_reg, bp_ev_next;
    logic          wp_ev_reg, wp_ev_next;
    logic [7:0]    wp_byte_reg, wp_byte_next;
    logic [7:0]    wp_left_reg, wp_left_next;
    bwm_wp_state_t wp_st_reg, wp_st_next;
    logic          sbp_reg, sbp_next;
    logic          hlt_reg, hlt_next;
    logic          catch_pend_reg, catch_pend_next;
    logic          catch_halt_reg, catch_halt_next;
    logic [4:0]    eff_reg, eff_next;
    logic [7:0]    status_reg, status_next;

    logic          bus_take;
    logic          bp_hit;
    logic          bp_link_bad;
    logic          wp_link_bad;
    logic          wp_addr_hit;
    logic [7:0]    wp_lanes_eff;
    logic [7:0]    wp_hits;
    logic [7:0]    wp_first;
    logic [3:0]    lbn_show;
    logic          catch_level;
    logic [4:0]    hyp_counter_partition_eff;

    assign bus_take  = HSEL && HREADY && HTRANS[1];
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign HRDATA    = rdata_reg;

    bwm_addr_match u_match (
        .bp_value    (bp_value_reg),
        .bp_bas      (bp_ctl_reg[BWM_CTL_BAS_LSB +: 4]),
        .bp_en       (bp_ctl_reg[BWM_CTL_EN_BIT]),
        .pc          (INSTR_PC),
        .compact     (INSTR_COMPACT),
        .length_flag (INSTR_LENGTH_FLAG),
        .hit         (bp_hit)
    );

    always_comb begin
        // Linked to missing or non-context-aware breakpoint
        bp_link_bad = bp_ctl_reg[BWM_CTL_LINKED_BIT] && !link_ok(
            bp_ctl_reg[BWM_CTL_LBN_LSB +: BWM_LBN_W], bp_ctl_reg, NUM_BP);
        wp_link_bad = wp_ctl_reg[BWM_CTL_LINKED_BIT] && !link_ok(
            wp_ctl_reg[BWM_CTL_LBN_LSB +: BWM_LBN_W], bp_ctl_reg, NUM_BP);
        lbn_show = wp_link_bad ? BWM_LBN_UNKNOWN
                 : wp_ctl_reg[BWM_CTL_LBN_LSB +: BWM_LBN_W];
        // Masked watchpoint ignores byte select
        if (wp_ctl_reg[BWM_CTL_MASK_LSB +: 5] != BWM_MASK_NONE) begin
            wp_lanes_eff = BWM_WBAS_ALL;
            wp_addr_hit  = ((DATA_ADDR ^ wp_value_reg) >>
                           wp_ctl_reg[BWM_CTL_MASK_LSB +: 5]) == 32'h0;
        end else begin
            wp_lanes_eff = wp_ctl_reg[BWM_CTL_BAS_LSB +: 8];
            wp_addr_hit  = DATA_ADDR[31:3] == wp_value_reg[31:3];
        end
        wp_hits = (DATA_VALID && wp_addr_hit && wp_ctl_reg[BWM_CTL_EN_BIT]
                   && !wp_link_bad) ? (wp_lanes_eff & DATA_LANES) : 8'h00;
        catch_level = catch_reg[CUR_EL];
        // Five bits stored, clamped only in NS EL1/EL0
        if (NONSECURE && (CUR_EL < 2'd2) &&
            (32'(hyp_counter_partition_reg) > 32'(NUM_COUNTER))) begin
            hyp_counter_partition_eff = 5'(NUM_COUNTER);
        end else begin
            hyp_counter_partition_eff = hyp_counter_partition_reg;
        end
    end

    // Bus register next state
    always_comb begin
        bp_value_next = bp_value_reg;
        bp_ctl_next   = bp_ctl_reg;
        wp_value_next = wp_value_reg;
        wp_ctl_next   = wp_ctl_reg;
        catch_next    = catch_reg;
        hyp_counter_partition_next     = hyp_counter_partition_reg;
        wr_pend_next  = bus_take && HWRITE;
        wr_addr_next  = bus_take ? HADDR[7:0] : wr_addr_reg;
        rdata_next    = rdata_reg;
        if (wr_pend_reg) begin
            case (wr_addr_reg)
                BWM_OFF_BP_VALUE:   bp_value_next = HWDATA;
                BWM_OFF_BP_CONTROL: bp_ctl_next   = HWDATA;
                BWM_OFF_WP_VALUE:   wp_value_next = HWDATA;
                BWM_OFF_WP_CONTROL: wp_ctl_next   = HWDATA;
                BWM_OFF_CATCH_CTRL: catch_next    = HWDATA[3:0];
                BWM_OFF_HYP_CONFIG: hyp_counter_partition_next     = HWDATA[4:0];
                default: ;
            endcase
        end
        if (bus_take && !HWRITE) begin
            case (HADDR[7:0])
                BWM_OFF_BP_VALUE:   rdata_next = bp_value_reg;
                BWM_OFF_BP_CONTROL: rdata_next = {bp_ctl_reg[31:20],
                    bp_link_bad ? BWM_LBN_UNKNOWN : bp_ctl_reg[19:16],
                    bp_ctl_reg[15:0]};
                BWM_OFF_WP_VALUE:   rdata_next = wp_value_reg;
                BWM_OFF_WP_CONTROL: rdata_next = {wp_ctl_reg[31:20],
                    lbn_show, wp_ctl_reg[15:0]};
                BWM_OFF_CATCH_CTRL: rdata_next = {28'h0, catch_reg};
                // Raw value, no clamp
                BWM_OFF_HYP_CONFIG: rdata_next = {27'h0, hyp_counter_partition_reg};
                BWM_OFF_STATUS:     rdata_next = {24'h0, status_reg};
                BWM_OFF_EFF_COUNT:  rdata_next = {27'h0, eff_reg};
                default:            rdata_next = BWM_RST_WORD;
            endcase
        end
    end

    // Event next state
    always_comb begin
        bp_ev_next      = INSTR_VALID && bp_hit && !bp_link_bad;
        // Condition field ignored for both instructions
        sbp_next        = INSTR_VALID && (INSTR_KIND == BWM_INSTR_SOFT_BP);
        hlt_next        = INSTR_VALID && (INSTR_KIND == BWM_INSTR_HALT);
        catch_pend_next = catch_pend_reg;
        catch_halt_next = 1'b0;
        // Halt at the next context sync instruction that is not a barrier
        if (catch_pend_reg && INSTR_VALID && INSTR_CTX_SYNC &&
            !INSTR_IS_BARRIER) begin
            catch_halt_next = 1'b1;
            catch_pend_next = 1'b0;
        end
        // A fresh catch outranks the clear, so none is lost
        if (INSTR_VALID && catch_level && HALT_ALLOWED) begin
            catch_pend_next = 1'b1;
        end
        if (!HALT_ALLOWED) begin
            catch_pend_next = 1'b0;
        end
        eff_next     = hyp_counter_partition_eff;
        wp_ev_next   = 1'b0;
        wp_byte_next = 8'h00;
        wp_left_next = wp_left_reg;
        wp_st_next   = wp_st_reg;
        // One event per byte, a lane each cycle
        case (wp_st_reg)
            BWM_WP_IDLE: begin
                wp_first = bwm_low_bit(wp_hits);
                if (wp_hits != 8'h00) begin
                    wp_ev_next   = 1'b1;
                    wp_byte_next = wp_first;
                    wp_left_next = wp_hits & ~wp_first;
                    if ((wp_hits & ~wp_first) != 8'h00) begin
                        wp_st_next = BWM_WP_SPLIT;
                    end
                end
            end
            BWM_WP_SPLIT: begin
                wp_first     = bwm_low_bit(wp_left_reg);
                wp_ev_next   = 1'b1;
                wp_byte_next = wp_first;
                wp_left_next = wp_left_reg & ~wp_first;
                if ((wp_left_reg & ~wp_first) == 8'h00) begin
                    wp_st_next = BWM_WP_IDLE;
                end
            end
            default: begin
                wp_first   = 8'h00;
                wp_st_next = BWM_WP_IDLE;
            end
        endcase
        status_next = {3'h0, catch_pend_reg, catch_halt_reg, hlt_reg,
                       wp_ev_reg, bp_ev_reg};
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            bp_value_reg   <= BWM_RST_WORD;
            bp_ctl_reg     <= BWM_RST_WORD;
            wp_value_reg   <= BWM_RST_WORD;
            wp_ctl_reg     <= BWM_RST_WORD;
            catch_reg      <= BWM_EL_NONE;
            hyp_counter_partition_reg       <= BWM_RST_HYP_COUNTER_PARTITION;
            wr_addr_reg    <= 8'h00;
            wr_pend_reg    <= 1'b0;
            rdata_reg      <= BWM_RST_WORD;
            bp_ev_reg      <= 1'b0;
            wp_ev_reg      <= 1'b0;
            wp_byte_reg    <= 8'h00;
            wp_left_reg    <= 8'h00;
            wp_st_reg      <= BWM_WP_IDLE;
            sbp_reg        <= 1'b0;
            hlt_reg        <= 1'b0;
            catch_pend_reg <= 1'b0;
            catch_halt_reg <= 1'b0;
            eff_reg        <= 5'h00;
            status_reg     <= 8'h00;
        end else begin
            bp_value_reg   <= bp_value_next;
            bp_ctl_reg     <= bp_ctl_next;
            wp_value_reg   <= wp_value_next;
            wp_ctl_reg     <= wp_ctl_next;
            catch_reg      <= catch_next;
            hyp_counter_partition_reg       <= hyp_counter_partition_next;
            wr_addr_reg    <= wr_addr_next;
            wr_pend_reg    <= wr_pend_next;
            rdata_reg      <= rdata_next;
            bp_ev_reg      <= bp_ev_next;
            wp_ev_reg      <= wp_ev_next;
            wp_byte_reg    <= wp_byte_next;
            wp_left_reg    <= wp_left_next;
            wp_st_reg      <= wp_st_next;
            sbp_reg        <= sbp_next;
            hlt_reg        <= hlt_next;
            catch_pend_reg <= catch_pend_next;
            catch_halt_reg <= catch_halt_next;
            eff_reg        <= eff_next;
            status_reg     <= status_next;
        end
    end

    assign BP_EVENT      = bp_ev_reg;
    assign WP_EVENT      = wp_ev_reg;
    assign WP_BYTE       = wp_byte_reg;
    assign SOFT_BP_TAKEN = sbp_reg;
    assign HALT_TAKEN    = hlt_reg;
    assign CATCH_HALT    = catch_halt_reg;
    assign EFF_COUNTERS  = eff_reg;

    a_soft_bp_uncond: assert property (INSTR_VALID
        && INSTR_KIND == BWM_INSTR_SOFT_BP && !INSTR_COND_PASS
        |=> SOFT_BP_TAKEN) else $error("soft breakpoint skipped");
    a_halt_uncond: assert property (INSTR_VALID
        && INSTR_KIND == BWM_INSTR_HALT && INSTR_COND != BWM_COND_ALWAYS
        |=> HALT_TAKEN) else $error("halt instruction skipped");
    a_bas_zero_off: assert property (
        bp_ctl_reg[BWM_CTL_BAS_LSB +: 4] == BWM_BAS_NONE |=> !BP_EVENT)
        else $error("zero byte select matched");
    a_hi_half_len: assert property (INSTR_VALID
        && !INSTR_COMPACT && INSTR_LENGTH_FLAG && !bp_link_bad
        && bp_ctl_reg[BWM_CTL_BAS_LSB +: 4] == BWM_BAS_HI_HALF |=> !BP_EVENT)
        else $error("upper half matched with length flag set");
    a_fixed_1100_hit: assert property (INSTR_VALID
        && !INSTR_COMPACT && !INSTR_LENGTH_FLAG && !bp_link_bad
        && bp_ctl_reg[BWM_CTL_EN_BIT] && INSTR_PC[31:2] == bp_value_reg[31:2]
        && bp_ctl_reg[BWM_CTL_BAS_LSB +: 4] == BWM_BAS_HI_HALF |=> BP_EVENT)
        else $error("byte select 1100 missed");
    a_compact_plus2: assert property (INSTR_VALID
        && INSTR_COMPACT && !bp_link_bad && bp_ctl_reg[BWM_CTL_EN_BIT]
        && INSTR_PC == (bp_value_reg + 32'h2)
        && bp_ctl_reg[BWM_CTL_BAS_LSB +: 4] == BWM_BAS_ALL |=> BP_EVENT)
        else $error("compact plus two missed");
    a_link_bad_quiet: assert property (bp_link_bad
        |=> !BP_EVENT) else $error("bad link raised event");
    a_mask_all_lanes: assert property (DATA_VALID && wp_addr_hit
        && wp_ctl_reg[BWM_CTL_EN_BIT] && !wp_link_bad
        && wp_ctl_reg[BWM_CTL_MASK_LSB +: 5] != BWM_MASK_NONE
        && wp_st_reg == BWM_WP_IDLE && DATA_LANES != 8'h00 |=> WP_EVENT)
        else $error("masked watchpoint used byte select");
    a_wp_one_byte: assert property (WP_EVENT |-> $onehot(WP_BYTE))
        else $error("watchpoint event not single byte");
    a_catch_halt: assert property (catch_pend_reg && HALT_ALLOWED
        && INSTR_VALID && INSTR_CTX_SYNC && !INSTR_IS_BARRIER |=> CATCH_HALT)
        else $error("catch halt late");
    a_hyp_counter_partition_clamp: assert property (NONSECURE && CUR_EL < 2'd2
        && 32'(hyp_counter_partition_reg) > 32'(NUM_COUNTER)
        |=> EFF_COUNTERS == 5'(NUM_COUNTER))
        else $error("partition not clamped");
    a_hyp_counter_partition_readback: assert property (bus_take && !HWRITE
        && HADDR[7:0] == BWM_OFF_HYP_CONFIG
        |=> HRDATA == {27'h0, $past(hyp_counter_partition_reg)})
        else $error("partition readback altered");
endmodule

// [bwm_core_model.sv]
/*
 * Core stream model: retires one instruction or one data access per call.
 * Assumes the bench clock; every change lands right after a rising edge.
 */
module bwm_core_model
    import bwm_pkg::*;
(
    input  wire logic        ref_clk,
    output logic             instr_valid,
    output logic [31:0]      instr_pc,
    output logic             instr_compact,
    output logic             instr_length_flag,
    output bwm_pkg::bwm_instr_t instr_kind,
    output logic [3:0]       instr_cond,
    output logic             instr_cond_pass,
    output logic             instr_ctx_sync,
    output logic             instr_is_barrier,
    output logic [1:0]       cur_el,
    output logic             nonsecure,
    output logic             halt_allowed,
    output logic             data_valid,
    output logic [31:0]      data_addr,
    output logic [7:0]       data_lanes
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {instr_valid, instr_pc, instr_compact, instr_length_flag} = '0;
        {instr_cond, instr_ctx_sync, instr_is_barrier} = '0;
        {cur_el, nonsecure, halt_allowed} = '0;
        {data_valid, data_addr, data_lanes} = '0;
        instr_kind = BWM_INSTR_OTHER;
        // Condition result ignored by the block; a failing code is harsher
        instr_cond_pass = 1'b0;
    end
    task automatic set_mode(input logic [1:0] el, input logic ns, ok);
        @(posedge ref_clk);
        {cur_el, nonsecure, halt_allowed} <= {el, ns, ok};
    endtask
    task automatic retire(input logic [31:0] pc, input logic cmp, lf,
                          input bwm_instr_t kind, input logic [3:0] cond,
                          input logic sync, bar);
        @(posedge ref_clk);
        {instr_valid, instr_pc, instr_compact} <= {1'b1, pc, cmp};
        {instr_length_flag, instr_cond} <= {lf, cond};
        {instr_ctx_sync, instr_is_barrier} <= {sync, bar};
        instr_kind <= kind;
        @(posedge ref_clk);
        // Stale PC turned over and kind reset so nothing matches by leftover value
        {instr_valid, instr_pc} <= {1'b0, ~pc};
        instr_kind <= BWM_INSTR_OTHER;
    endtask
    task automatic access(input logic [31:0] a, input logic [7:0] ln);
        @(posedge ref_clk);
        {data_valid, data_addr, data_lanes} <= {1'b1, a, ln};
        @(posedge ref_clk);
        {data_valid, data_addr, data_lanes} <= {1'b0, ~a, ~ln};
    endtask
endmodule

// [tb_breakpoint_watchpoint_match.sv]
/*
 * Self-checking bench for the debug event block: AHB-Lite register
 * tasks plus the core stream model. Assumes a zero-wait slave.
 */
module tb_breakpoint_watchpoint_match;
    timeunit 1ns;
    timeprecision 1ps;
    import bwm_pkg::*;
    localparam int NCNT = 6;
    logic ref_clk, nrst, hsel, hwrite, hready, hresp;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic bp_ev, wp_ev, sbp, halt_instr, catch;
    logic [7:0] wp_byte;
    logic [4:0] eff;
    int err_total, compares, catch_n, n0;
    wire logic iv, ic, il, icp, isy, ib, ns, ha, dv;
    wire logic [31:0] ipc, da;
    wire logic [3:0] icd;
    wire logic [1:0] el;
    wire logic [7:0] dl;
    wire bwm_instr_t ik;
    bwm_debug_events #(.NUM_BP(4), .NUM_COUNTER(NCNT)) u_bwm_debug_events (
        .REF_CLK(ref_clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .INSTR_VALID(iv), .INSTR_PC(ipc), .INSTR_COMPACT(ic),
        .INSTR_LENGTH_FLAG(il), .INSTR_KIND(ik), .INSTR_COND(icd),
        .INSTR_COND_PASS(icp), .INSTR_CTX_SYNC(isy), .INSTR_IS_BARRIER(ib),
        .CUR_EL(el), .NONSECURE(ns), .HALT_ALLOWED(ha), .DATA_VALID(dv),
        .DATA_ADDR(da), .DATA_LANES(dl), .BP_EVENT(bp_ev), .WP_EVENT(wp_ev),
        .WP_BYTE(wp_byte), .SOFT_BP_TAKEN(sbp), .HALT_TAKEN(halt_instr),
        .CATCH_HALT(catch), .EFF_COUNTERS(eff));
    bwm_core_model u_bwm_core_model (
        .ref_clk(ref_clk), .instr_valid(iv), .instr_pc(ipc),
        .instr_compact(ic), .instr_length_flag(il), .instr_kind(ik),
        .instr_cond(icd), .instr_cond_pass(icp), .instr_ctx_sync(isy),
        .instr_is_barrier(ib), .cur_el(el), .nonsecure(ns),
        .halt_allowed(ha), .data_valid(dv), .data_addr(da),
        .data_lanes(dl));
    always #10 ref_clk = ~ref_clk;
    // Catch halt may come early, so pulses are counted rather than timed
    always @(posedge ref_clk) if (catch === 1'b1) catch_n++;
    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge ref_clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
        do @(posedge ref_clk); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
        do @(posedge ref_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic report_and_stop;
        if (err_total == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    logic [4:0] hv [5] = '{5'h00, 5'h03, 5'h06, 5'h07, 5'h1f};
    logic [4:0] he [5] = '{5'h00, 5'h03, 5'h06, 5'h06, 5'h06};
    logic [3:0] bs [4] = '{4'h0, 4'hc, 4'hc, 4'hf};
    logic [3:0] cd [3] = '{4'h0, 4'hb, 4'he};
    initial begin
        {ref_clk, nrst, hsel, haddr, htrans, hwrite, hwdata} = '0;
        hsize = 3'h2;
        {err_total, compares, catch_n} = '0;
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(BWM_OFF_HYP_CONFIG, 32'h1f, "hyp_counter_partition_reset");
        u_bwm_core_model.set_mode(2'd1, 1'b1, 1'b0);
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, BWM_OFF_HYP_CONFIG, {27'h0, hv[i]});
            rd(BWM_OFF_HYP_CONFIG, {27'h0, hv[i]}, "hyp_counter_partition");
            chk("eff_count", {27'h0, he[i]}, {27'h0, eff});
        end
        u_bwm_core_model.set_mode(2'd2, 1'b1, 1'b0);
        @(posedge ref_clk);
        #1 chk("eff_el2", 32'h1f, {27'h0, eff});
        xfer(1'b1, 8'h40, 32'hffffffff);
        rd(8'h40, 32'h0, "unmapped");
        xfer(1'b1, BWM_OFF_BP_VALUE, 32'h2000);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, BWM_OFF_BP_CONTROL, {23'h0, bs[i], 5'h01});
            u_bwm_core_model.retire(32'h2000 + 32'(i / 3 * 2), i == 3,
                                    i == 2, BWM_INSTR_OTHER, 4'he, 0, 0);
            #1 chk("bp", 32'(i % 2), 32'(bp_ev));
        end
        xfer(1'b1, BWM_OFF_BP_CONTROL, 32'h000501e5);
        rd(BWM_OFF_BP_CONTROL, 32'h000f01e5, "bp_lbn");
        u_bwm_core_model.retire(32'h2000, 0, 0, BWM_INSTR_OTHER, 4'he, 0, 0);
        #1 chk("bp_link", 32'h0, 32'(bp_ev));
        xfer(1'b1, BWM_OFF_BP_CONTROL, 32'h0);
        for (int i = 0; i < 6; i++) begin
            u_bwm_core_model.retire(32'h100, 0, 0, i < 3 ? BWM_INSTR_SOFT_BP
                                    : BWM_INSTR_HALT, cd[i % 3], 0, 0);
            #1 chk("taken", 32'(1 + (i < 3)), {30'h0, sbp, halt_instr});
        end
        xfer(1'b1, BWM_OFF_WP_VALUE, 32'h3000);
        for (int i = 0; i < 2; i++) begin
            xfer(1'b1, BWM_OFF_WP_CONTROL, {12'h0, 4'(5 * (1 - i)), 16'h1fe5});
            u_bwm_core_model.access(32'h3000, 8'hff);
            #1 chk("wp_link", 32'h0, {31'h0, wp_ev});
            rd(BWM_OFF_WP_CONTROL, 32'h000f1fe5, "wp_lbn");
        end
        xfer(1'b1, BWM_OFF_WP_CONTROL, 32'h000000a1);
        u_bwm_core_model.access(32'h3000, 8'hff);
        #1 chk("wp_byte", 32'h101, {23'h0, wp_ev, wp_byte});
        @(posedge ref_clk);
        #1 chk("wp_byte", 32'h104, {23'h0, wp_ev, wp_byte});
        @(posedge ref_clk);
        #1 chk("wp_byte", 32'h0, {23'h0, wp_ev, wp_byte});
        xfer(1'b1, BWM_OFF_WP_CONTROL, 32'h03000021);
        u_bwm_core_model.access(32'h3000, 8'h80);
        #1 chk("wp_mask", 32'h180, {23'h0, wp_ev, wp_byte});
        xfer(1'b1, BWM_OFF_CATCH_CTRL, 32'h2);
        for (int k = 0; k < 2; k++) begin
            u_bwm_core_model.set_mode(2'd1, 1'b1, k == 1);
            n0 = catch_n;
            u_bwm_core_model.retire(32'h400, 0, 0, BWM_INSTR_OTHER, 4'he, 0, 0);
            u_bwm_core_model.retire(32'h404, 0, 0, BWM_INSTR_OTHER, 4'he, 1, 1);
            u_bwm_core_model.retire(32'h408, 0, 0, BWM_INSTR_OTHER, 4'he, 1, 0);
            @(posedge ref_clk);
            #1 chk("catch", k, (catch_n - n0) != 0);
        end
        report_and_stop;
    end
    initial begin
        #100000;
        err_total++;
        report_and_stop;
    end
endmodule
